// File: include/ofd_pkg.sv
// ofd_pkg: constants and types shared by the operand field decoder files.
// assumes an 8-bit byte stream and a 16-bit program/data address space.
package ofd_pkg;

  localparam int unsigned OFD_BYTE_W = 8;
  localparam int unsigned OFD_ADDR_W = 16;
  localparam int unsigned OFD_EREG_W = 12;
  localparam int unsigned OFD_BIT_W = 3;

  // escape marker in the upper nibble of an 8-bit register address
  localparam logic [3:0] OFD_ESC_NIBBLE = 4'hE;
  // register-to-register add opcode
  localparam logic [7:0] OFD_OPC_ADD_RR = 8'h04;
  // number of operand bytes that follow the add opcode
  localparam logic [1:0] OFD_ADD_OPND_CNT = 2'h2;

  // values after reset, one per register width
  localparam logic [15:0] OFD_RST_ADDR = 16'h0000;
  localparam logic [11:0] OFD_RST_RADDR = 12'h000;
  localparam logic [7:0] OFD_RST_BYTE = 8'h00;
  localparam logic [3:0] OFD_RST_PAIR = 4'h0;
  localparam logic [2:0] OFD_RST_BIT = 3'h0;
  localparam logic OFD_RST_FLAG = 1'b0;

  // operand kind presented by the fetch side with each operand byte
  typedef enum logic [3:0] {
    OFD_K_REG,
    OFD_K_BIT,
    OFD_K_POL,
    OFD_K_IMM,
    OFD_K_VEC,
    OFD_K_DA_HI,
    OFD_K_DA_LO,
    OFD_K_ER_HI,
    OFD_K_ER_LO,
    OFD_K_WPAIR,
    OFD_K_RPAIR,
    OFD_K_REL,
    OFD_K_IDX
  } ofd_kind_e;

endpackage : ofd_pkg

// File: include/ofd_adder_if.sv
// ofd_adder_if: operands and sum between the decoder and its add unit.
// assumes a single clock domain; purely combinational bundle.
`timescale 1ns/100ps
interface ofd_adder_if;
  import ofd_pkg::*;
  logic [OFD_BYTE_W-1:0] src;
  logic [OFD_BYTE_W-1:0] dst;
  logic [OFD_BYTE_W-1:0] sum;
  logic carry;
  logic [OFD_ADDR_W-1:0] base;
  logic [OFD_BYTE_W-1:0] offset;
  logic [OFD_ADDR_W-1:0] target;
  modport dec (output src, output dst, output base, output offset,
               input sum, input carry, input target);
  modport alu (input src, input dst, input base, input offset,
               output sum, output carry, output target);
endinterface : ofd_adder_if

// File: core/ofd_adder.sv
// ofd_adder: byte add for the add operation and signed offset address add.
// assumes operands are stable while the decoder samples the results.
`timescale 1ns/100ps
module ofd_adder
  import ofd_pkg::*;
(
  ofd_adder_if.alu bus
);
  logic [OFD_BYTE_W:0] wide_sum;
  logic [OFD_ADDR_W-1:0] sext_off;

  always_comb begin
    wide_sum = {1'b0, bus.src} + {1'b0, bus.dst};
    // widen before adding so negative offsets borrow correctly
    sext_off = {{(OFD_ADDR_W-OFD_BYTE_W){bus.offset[OFD_BYTE_W-1]}}, bus.offset};
  end

  assign bus.sum = wide_sum[OFD_BYTE_W-1:0];
  assign bus.carry = wide_sum[OFD_BYTE_W];
  assign bus.target = bus.base + sext_off;

endmodule : ofd_adder

// File: core/ofd_decoder.sv
// ofd_decoder: operand field decoder fed byte by byte from instruction fetch.
// assumes fetch tags each operand byte with its kind and the next pc.
// Summary of operation
// - after opcode 04 the source byte comes first, then the destination byte.
// - an 8-bit register address reaches 0-255, but upper nibble E picks working reg 0-15.
// - a bit-select field is three bits choosing bit 0 to 7.
// - a direct address is a full 16-bit value 0000H to FFFFH.
// - an extended register address is 12 bits, 000H to FFFH.
// - an immediate operand is one byte taken straight from the stream.
// - a working pair names only even pairs 0 to 14, even reg then the odd one.
// - a register pair addresses only even locations 00H to FEH.
// - a relative offset is a signed byte added to the next instruction address.
// - a polarity operand is one bit choosing which bit value is acted on.
// - a trap vector is one byte, 00H to FFH.
// - add sums source and destination and writes the result to the destination.
`timescale 1ns/100ps
module ofd_decoder
  import ofd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic opc_valid_i,
  input wire logic [7:0] opc_i,
  input wire logic opnd_valid_i,
  input wire logic [7:0] opnd_i,
  input wire logic [3:0] opnd_kind_i,
  input wire logic [15:0] next_pc_i,
  input wire logic [15:0] index_base_i,
  input wire logic [3:0] reg_ptr_i,
  input wire logic [7:0] src_val_i,
  input wire logic [7:0] dst_val_i,
  input wire logic operands_valid_i,
  output logic [11:0] reg_addr_o,
  output logic reg_is_work_o,
  output logic [2:0] bit_sel_o,
  output logic polarity_o,
  output logic [7:0] immediate_operand_o,
  output logic [7:0] vector_o,
  output logic [15:0] direct_address_operand_o,
  output logic [11:0] extended_register_operand_o,
  output logic [3:0] work_pair_operand_o,
  output logic [7:0] reg_pair_operand_o,
  output logic [15:0] rel_target_o,
  output logic [15:0] idx_addr_o,
  output logic add_src_ok_o,
  output logic [11:0] add_src_addr_o,
  output logic [11:0] add_dst_addr_o,
  output logic add_wr_o,
  output logic [11:0] add_wr_addr_o,
  output logic [7:0] add_wr_data_o,
  output logic add_carry_o
);
  typedef enum logic [1:0] {OFD_IDLE, OFD_SRC, OFD_DST, OFD_EXEC} ofd_add_e;
  ofd_add_e st_q, st_d;

  logic [11:0] reg_addr_q, reg_addr_d;
  logic reg_work_q, reg_work_d;
  logic [2:0] bit_q, bit_d;
  logic pol_q, pol_d;
  logic [7:0] imm_q, imm_d;
  logic [7:0] vec_q, vec_d;
  logic [15:0] da_q, da_d;
  logic [11:0] er_q, er_d;
  logic [3:0] wp_q, wp_d;
  logic [7:0] rp_q, rp_d;
  logic [15:0] rel_q, rel_d;
  logic [15:0] idx_q, idx_d;
  logic [11:0] asrc_q, asrc_d;
  logic [11:0] adst_q, adst_d;
  logic awr_q, awr_d;
  logic [7:0] awd_q, awd_d;
  logic acy_q, acy_d;
  logic [11:0] reg_full;
  ofd_adder_if add_bus ();

  ofd_adder u_adder (
    .bus(add_bus)
  );

  // escape decode: working regs live in the 16-byte group selected by the pointer
  function automatic logic [11:0] ofd_reg_map(input logic [7:0] b, input logic [3:0] rp);
    if (b[7:4] == OFD_ESC_NIBBLE) begin
      ofd_reg_map = {rp, 4'h0, b[3:0]};
    end else begin
      ofd_reg_map = {4'h0, b};
    end
  endfunction : ofd_reg_map

  assign reg_full = ofd_reg_map(opnd_i, reg_ptr_i);

  always_comb begin
    add_bus.src = src_val_i;
    add_bus.dst = dst_val_i;
    // one adder path serves both relative and indexed forms
    if (opnd_kind_i == OFD_K_IDX) begin
      add_bus.base = index_base_i;
    end else begin
      add_bus.base = next_pc_i;
    end
    add_bus.offset = opnd_i;
  end

  // register-like fields: plain or escaped register, working pair, register pair
  always_comb begin
    reg_addr_d = reg_addr_q;
    reg_work_d = reg_work_q;
    wp_d = wp_q;
    rp_d = rp_q;
    if (opnd_valid_i) begin
      unique case (opnd_kind_i)
        OFD_K_REG: begin
          reg_addr_d = reg_full;
          reg_work_d = (opnd_i[7:4] == OFD_ESC_NIBBLE);
        end
        // low bit forced clear: odd pair codes are not encodable
        OFD_K_WPAIR: begin
          wp_d = {opnd_i[3:1], 1'b0};
        end
        OFD_K_RPAIR: begin
          rp_d = {opnd_i[7:1], 1'b0};
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_addr_q <= OFD_RST_RADDR;
      reg_work_q <= OFD_RST_FLAG;
      wp_q <= OFD_RST_PAIR;
      rp_q <= OFD_RST_BYTE;
    end else begin
      reg_addr_q <= reg_addr_d;
      reg_work_q <= reg_work_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // single-byte fields, held until the next byte of the same kind
  always_comb begin
    bit_d = bit_q;
    pol_d = pol_q;
    imm_d = imm_q;
    vec_d = vec_q;
    if (opnd_valid_i) begin
      unique case (opnd_kind_i)
        OFD_K_BIT: begin
          bit_d = opnd_i[OFD_BIT_W-1:0];
        end
        OFD_K_POL: begin
          pol_d = opnd_i[0];
        end
        OFD_K_IMM: begin
          imm_d = opnd_i;
        end
        OFD_K_VEC: begin
          vec_d = opnd_i;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_q <= OFD_RST_BIT;
      pol_q <= OFD_RST_FLAG;
      imm_q <= OFD_RST_BYTE;
      vec_q <= OFD_RST_BYTE;
    end else begin
      bit_q <= bit_d;
      pol_q <= pol_d;
      imm_q <= imm_d;
      vec_q <= vec_d;
    end
  end

  // two-byte fields: each half lands alone, so either byte order works
  always_comb begin
    da_d = da_q;
    er_d = er_q;
    if (opnd_valid_i) begin
      unique case (opnd_kind_i)
        OFD_K_DA_HI: begin
          da_d = {opnd_i, da_q[7:0]};
        end
        OFD_K_DA_LO: begin
          da_d = {da_q[15:8], opnd_i};
        end
        // only the low nibble of the high byte fits a 12-bit register address
        OFD_K_ER_HI: begin
          er_d = {opnd_i[3:0], er_q[7:0]};
        end
        OFD_K_ER_LO: begin
          er_d = {er_q[11:8], opnd_i};
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      da_q <= OFD_RST_ADDR;
      er_q <= OFD_RST_RADDR;
    end else begin
      da_q <= da_d;
      er_q <= er_d;
    end
  end

  // offset targets come straight from the shared adder
  always_comb begin
    rel_d = rel_q;
    idx_d = idx_q;
    if (opnd_valid_i) begin
      unique case (opnd_kind_i)
        OFD_K_REL: begin
          rel_d = add_bus.target;
        end
        OFD_K_IDX: begin
          idx_d = add_bus.target;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rel_q <= OFD_RST_ADDR;
      idx_q <= OFD_RST_ADDR;
    end else begin
      rel_q <= rel_d;
      idx_q <= idx_d;
    end
  end

  // add sequence: opcode, source byte, destination byte, write-back
  always_comb begin
    st_d = st_q;
    asrc_d = asrc_q;
    adst_d = adst_q;
    awr_d = 1'b0;
    awd_d = awd_q;
    acy_d = acy_q;
    unique case (st_q)
      OFD_IDLE: begin
        if (opc_valid_i && opc_i == OFD_OPC_ADD_RR) begin
          st_d = OFD_SRC;
        end
      end
      OFD_SRC: begin
        if (opnd_valid_i) begin
          asrc_d = reg_full;
          st_d = OFD_DST;
        end
      end
      OFD_DST: begin
        if (opnd_valid_i) begin
          adst_d = reg_full;
          st_d = OFD_EXEC;
        end
      end
      OFD_EXEC: begin
        if (operands_valid_i) begin
          awr_d = 1'b1;
          awd_d = add_bus.sum;
          acy_d = add_bus.carry;
          st_d = OFD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= OFD_IDLE;
      asrc_q <= OFD_RST_RADDR;
      adst_q <= OFD_RST_RADDR;
      awr_q <= OFD_RST_FLAG;
      awd_q <= OFD_RST_BYTE;
      acy_q <= OFD_RST_FLAG;
    end else begin
      st_q <= st_d;
      asrc_q <= asrc_d;
      adst_q <= adst_d;
      awr_q <= awr_d;
      awd_q <= awd_d;
      acy_q <= acy_d;
    end
  end

  assign reg_addr_o = reg_addr_q;
  assign reg_is_work_o = reg_work_q;
  assign bit_sel_o = bit_q;
  assign polarity_o = pol_q;
  assign immediate_operand_o = imm_q;
  assign vector_o = vec_q;
  assign direct_address_operand_o = da_q;
  assign extended_register_operand_o = er_q;
  assign work_pair_operand_o = wp_q;
  assign reg_pair_operand_o = rp_q;
  assign rel_target_o = rel_q;
  assign idx_addr_o = idx_q;
  assign add_src_ok_o = (st_q == OFD_EXEC);
  assign add_src_addr_o = asrc_q;
  assign add_dst_addr_o = adst_q;
  assign add_wr_o = awr_q;
  assign add_wr_addr_o = adst_q;
  assign add_wr_data_o = awd_q;
  assign add_carry_o = acy_q;

endmodule : ofd_decoder

// File: tb/ofd_decoder_asserts.sv
// port checks for ofd_decoder
// assumes bind from the bench top, one clock
`timescale 1ns/100ps
module ofd_decoder_asserts (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic opnd_valid_i,
  input wire logic [7:0] opnd_i,
  input wire logic [3:0] opnd_kind_i,
  input wire logic [15:0] next_pc_i,
  input wire logic [15:0] index_base_i,
  input wire logic [3:0] reg_ptr_i,
  input wire logic operands_valid_i,
  input wire logic [7:0] src_val_i,
  input wire logic [7:0] dst_val_i,
  input wire logic add_src_ok_o,
  input wire logic [7:0] add_wr_data_o,
  input wire logic add_carry_o,
  input wire logic [11:0] reg_addr_o,
  input wire logic reg_is_work_o,
  input wire logic [2:0] bit_sel_o,
  input wire logic [7:0] immediate_operand_o,
  input wire logic [7:0] reg_pair_operand_o,
  input wire logic [15:0] rel_target_o,
  input wire logic [15:0] idx_addr_o,
  input wire logic add_wr_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // one-hot of the kind taken at this edge
  wire logic [12:0] kh = opnd_valid_i ? 13'h1 << opnd_kind_i : 13'h0;
  wire logic esc = opnd_i[7:4] == 4'hE;
  wire logic [15:0] sx = {{8{opnd_i[7]}}, opnd_i};
  a_imm_byte: assert property (kh[3] |=> immediate_operand_o == $past(opnd_i))
    else $error("imm");
  a_bit_field: assert property (kh[1] |=> bit_sel_o == $past(opnd_i[2:0]))
    else $error("bit");
  a_reg_escape: assert property (kh[0] && esc |=> reg_is_work_o &&
    reg_addr_o == {$past(reg_ptr_i), 4'h0, $past(opnd_i[3:0])}) else $error("esc");
  a_reg_plain: assert property (kh[0] && !esc |=> !reg_is_work_o &&
    reg_addr_o == {4'h0, $past(opnd_i)}) else $error("reg");
  a_pair_even: assert property (kh[10] |=>
    reg_pair_operand_o == {$past(opnd_i[7:1]), 1'b0}) else $error("pair");
  a_rel_sum: assert property (kh[11] |=>
    rel_target_o == $past(next_pc_i) + $past(sx)) else $error("rel");
  a_idx_sum: assert property (kh[12] |=>
    idx_addr_o == $past(index_base_i) + $past(sx)) else $error("idx");
  a_wr_pulse: assert property (add_wr_o |=> !add_wr_o) else $error("wr");
  a_add_sum: assert property (add_src_ok_o && operands_valid_i |=> add_wr_o &&
    {add_carry_o, add_wr_data_o} == $past(src_val_i) + $past(dst_val_i)) else $error("sum");
endmodule : ofd_decoder_asserts

// File: tb/ofd_fetch_model.sv
// fetch side model: hands bytes and add values to the decoder
// assumes the bench calls its tasks; drives just after rising edges
`timescale 1ns/100ps
module ofd_fetch_model (
  input wire logic clk_i,
  input wire logic wr_i,
  output logic opc_v_o,
  output logic [7:0] opc_o,
  output logic opnd_v_o,
  output logic [7:0] opnd_o,
  output logic [3:0] kind_o,
  output logic [15:0] pc_o,
  output logic [15:0] base_o,
  output logic [3:0] rp_o,
  output logic [7:0] sv_o,
  output logic [7:0] dv_o,
  output logic ov_o
);
  initial {opc_v_o, opc_o, opnd_v_o, opnd_o, kind_o, pc_o, base_o, rp_o, sv_o, dv_o, ov_o} = '0;
  // released byte lines show the inverse so stale data never matches
  task put(input logic [3:0] k, input logic [7:0] b, input logic o);
    @(posedge clk_i);
    if (o) {opc_v_o, opc_o} <= {1'b1, b};
    else {opnd_v_o, kind_o, opnd_o} <= {1'b1, k, b};
    {pc_o, base_o, rp_o} <= {16'($urandom), 16'($urandom), 4'($urandom)};
    @(posedge clk_i);
    {opc_v_o, opnd_v_o, opnd_o, opc_o} <= {2'b00, ~b, ~b};
  endtask : put
  task exec(input logic [7:0] s, input logic [7:0] d, output logic seen);
    @(posedge clk_i);
    {sv_o, dv_o, ov_o} <= {s, d, 1'b1};
    seen = 1'b0;
    for (int n = 0; n < 10 && !seen; n++) begin
      @(posedge clk_i);
      seen = wr_i;
    end
    {sv_o, dv_o, ov_o} <= {~s, ~d, 1'b0};
  endtask : exec
endmodule : ofd_fetch_model

// File: tb/testbench.sv
// bench top: fetch model feeds the decoder, an integer model checks it
// assumes package, design, fetch model and checker compiled first
`timescale 1ns/100ps
module testbench;
  import ofd_pkg::*;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  int fails = 0;
  int compares = 0;
  logic [15:0] da = '0;
  logic [11:0] er = '0;
  wire logic ocv, ndv, ovl, wr;
  wire logic [7:0] oc, nd, sv, dv;
  wire logic [3:0] kd, rp;
  wire logic [15:0] pc, bs;
  always #5 core_clk_i = ~core_clk_i;
  ofd_fetch_model fm (.clk_i(core_clk_i), .wr_i(wr), .opc_v_o(ocv), .opc_o(oc), .opnd_v_o(ndv),
    .opnd_o(nd), .kind_o(kd), .pc_o(pc), .base_o(bs), .rp_o(rp), .sv_o(sv), .dv_o(dv), .ov_o(ovl));
  ofd_decoder uut (.core_clk_i, .arst_n_i, .opc_valid_i(ocv), .opc_i(oc), .opnd_valid_i(ndv),
    .opnd_i(nd), .opnd_kind_i(kd), .next_pc_i(pc), .index_base_i(bs), .reg_ptr_i(rp),
    .src_val_i(sv), .dst_val_i(dv), .operands_valid_i(ovl), .reg_addr_o(), .reg_is_work_o(),
    .bit_sel_o(), .polarity_o(), .immediate_operand_o(), .vector_o(),
    .direct_address_operand_o(), .extended_register_operand_o(), .work_pair_operand_o(),
    .reg_pair_operand_o(), .rel_target_o(), .idx_addr_o(), .add_src_ok_o(), .add_src_addr_o(),
    .add_dst_addr_o(), .add_wr_o(wr), .add_wr_addr_o(), .add_wr_data_o(), .add_carry_o());
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [12:0] map(input logic [7:0] b, input logic [3:0] r);
    return b[7:4] == 4'hE ? {1'b1, r, 4'h0, b[3:0]} : {5'h0, b};
  endfunction : map
  task final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    fails++;
    final_report();
  end
  initial begin
    logic [7:0] b;
    logic [3:0] k;
    logic [12:0] a;
    logic [15:0] q;
    logic seen;
    void'($urandom(96));
    repeat (12) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      k = i < 13 ? 4'(i) : 4'($urandom_range(12));
      // signed and unsigned edges first, then random bytes
      b = i < 26 ? 8'(32'h807FFF00 >> (8 * (i % 4))) : 8'($urandom);
      fm.put(k, b, 1'b0);
      @(negedge core_clk_i);
      case (k)
        4'h0: chk({uut.reg_is_work_o, uut.reg_addr_o}, map(b, rp));
        4'h1: chk(uut.bit_sel_o, b[2:0]);
        4'h2: chk(uut.polarity_o, b[0]);
        4'h3: chk(uut.immediate_operand_o, b);
        4'h4: chk(uut.vector_o, b);
        4'h5: da[15:8] = b;
        4'h6: da[7:0] = b;
        4'h7: er[11:8] = b[3:0];
        4'h8: er[7:0] = b;
        4'h9: chk(uut.work_pair_operand_o, {b[3:1], 1'b0});
        4'hA: chk(uut.reg_pair_operand_o, {b[7:1], 1'b0});
        4'hB: chk(uut.rel_target_o, pc + {{8{b[7]}}, b});
        default: chk(uut.idx_addr_o, bs + {{8{b[7]}}, b});
      endcase
      chk(uut.direct_address_operand_o, da);
      chk(uut.extended_register_operand_o, er);
    end
    $display("field test done");
    for (int j = 0; j < 24; j++) begin
      q = 16'($urandom);
      b = 8'($urandom) | (j == 0 ? 8'hE0 : 8'h00);
      fm.put(4'h0, j == 3 ? 8'h05 : OFD_OPC_ADD_RR, 1'b1);
      fm.put(4'($urandom_range(12)), b, 1'b0);
      a = map(b, rp);
      b = 8'($urandom);
      fm.put(4'($urandom_range(12)), b, 1'b0);
      @(negedge core_clk_i);
      chk(uut.add_src_ok_o, j != 3);
      fm.exec(q[15:8], q[7:0], seen);
      @(negedge core_clk_i);
      chk(seen, j != 3);
      if (seen) begin
        chk(uut.add_src_addr_o, a[11:0]);
        chk(uut.add_dst_addr_o, 12'(map(b, rp)));
        chk(uut.add_wr_addr_o, 12'(map(b, rp)));
        chk({uut.add_carry_o, uut.add_wr_data_o}, q[15:8] + q[7:0]);
      end
    end
    $display("add test done");
    final_report();
  end
endmodule : testbench
bind ofd_decoder ofd_decoder_asserts chk (.*);
